// *** core/hotplug_expander_pkg.sv ***
// Package with register map, field layout, reset values and transaction states of the expander interface
package hotplug_expander_pkg;
  localparam logic [11:0] interface_offset = 12'h0B8;
  localparam logic [11:0] irq_status_offset = 12'h0C0;
  localparam logic [11:0] irq_mask_offset = 12'h0C4;
  localparam logic [11:0] bus_address_offset = 12'h0C8;
  localparam int first_port_lsb = 0;
  localparam int second_port_lsb = 8;
  localparam int port_width = 8;
  localparam int reload_bit = 24;
  localparam int test_mode_bit = 25;
  localparam int done_bit = 31;
  localparam logic [31:0] interface_reset = 32'h00000000;
  localparam logic [7:0] out_mask_reset = 8'h00;
  localparam int irq_bits = 1;
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_busy = 2'b10
  } xfer_state_t;
endpackage

// *** core/hotplug_expander_regs.sv ***
// Register bank of the hot-plug I/O expander link, APB slave with done interrupt
//
// Functional notes
// - Bits 7:0 shadow first port hot-plug: sampled inputs and driven outputs.
// - Bits 15:8 shadow second port hot-plug with the same read view.
// - Shadow writes are dropped while test mode is clear.
// - Test mode: expander outputs come from written shadow values, not the core.
// - Shadow bits mapped to expander inputs are read-only always.
// - Writing one to reload starts an expander refresh transaction.
// - Reload bit reads zero.
// - Done sets when a reload or address-write transaction completes; write one clears.
// - Test-mode shadow write starts an output update; done sets on completion.
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
module hotplug_expander_regs
  import hotplug_expander_pkg::*;
#(
  parameter logic [7:0] first_out_mask = 8'h0F,  // Which first-port bits are outputs
  parameter logic [7:0] second_out_mask = 8'h0F  // Which second-port bits are outputs
) (
  input wire logic pclk,  // Core clock, 100 MHz
  input wire logic presetn,  // Asynchronous reset, active low
  input wire logic psel,  // APB select
  input wire logic penable,  // APB access phase
  input wire logic pwrite,  // APB direction
  input wire logic [11:0] paddr,  // APB byte address
  input wire logic [31:0] pwdata,  // APB write data
  output logic [31:0] prdata,  // APB read data
  output logic pready,  // APB ready
  output logic pslverr,  // APB error, unmapped address
  input wire logic [7:0] core_first_out,  // Core hot-plug outputs, first port
  input wire logic [7:0] core_second_out,  // Core hot-plug outputs, second port
  output logic [7:0] expander_first_out,  // Values sent to expander, first port
  output logic [7:0] expander_second_out,  // Values sent to expander, second port
  output logic xfer_start,  // Pulse: run one expander SMBus transaction
  output logic xfer_refresh,  // With start: full refresh rather than output update
  input wire logic xfer_done,  // Pulse from SMBus master: transaction finished
  input wire logic [7:0] expander_first_in,  // Inputs last read from expander, first port
  input wire logic [7:0] expander_second_in,  // Inputs last read from expander, second port
  output logic irq  // Level interrupt, unmasked done pending
);

  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic [7:0] first_sh;
    logic [7:0] second_sh;
    logic test_mode;
    logic done;
    logic mask;
    logic [6:0] bus_addr;
    logic [7:0] out_first;
    logic [7:0] out_second;
    logic start;
    logic refresh;
    logic pending;
    xfer_state_t state;
    logic irq;
  } state_t;

  state_t r;
  state_t next_r;

  // Merge shadow value: output bits from source, input bits from sampled inputs
  function automatic logic [7:0] merge(input logic [7:0] outs, input logic [7:0] ins,
                                       input logic [7:0] omask);
    merge = (outs & omask) | (ins & ~omask);
  endfunction

  logic wr_acc;
  logic rd_acc;
  logic hit_if;
  logic hit_st;
  logic hit_mk;
  logic hit_ad;
  assign wr_acc = psel && penable && pwrite && !r.ready;
  assign rd_acc = psel && penable && !pwrite && !r.ready;
  assign hit_if = paddr == interface_offset;
  assign hit_st = paddr == irq_status_offset;
  assign hit_mk = paddr == irq_mask_offset;
  assign hit_ad = paddr == bus_address_offset;

  // Next-state logic for bus, shadows, transaction sequencer and interrupt
  always_comb begin
    logic [7:0] src_first;
    logic [7:0] src_second;
    logic set_done;
    logic req_refresh;
    logic req_update;
    next_r = r;
    src_first = '0;
    src_second = '0;
    set_done = 1'b0;
    req_refresh = 1'b0;
    req_update = 1'b0;
    next_r.ready = 1'b0;
    next_r.slverr = 1'b0;
    next_r.start = 1'b0;
    // Bus access completes one cycle after the access phase begins
    if (psel && penable && !r.ready) begin
      next_r.ready = 1'b1;
      next_r.slverr = !(hit_if || hit_st || hit_mk || hit_ad);
    end
    if (rd_acc) begin
      next_r.rdata = '0;
      if (hit_if) begin
        next_r.rdata[first_port_lsb +: port_width] =
          merge(r.out_first, expander_first_in, first_out_mask);
        next_r.rdata[second_port_lsb +: port_width] =
          merge(r.out_second, expander_second_in, second_out_mask);
        next_r.rdata[test_mode_bit] = r.test_mode;
        next_r.rdata[done_bit] = r.done;
      end else if (hit_st) begin
        next_r.rdata[0] = r.done;
      end else if (hit_mk) begin
        next_r.rdata[0] = r.mask;
      end else if (hit_ad) begin
        next_r.rdata[6:0] = r.bus_addr;
      end
    end
    if (wr_acc && hit_if) begin
      next_r.test_mode = pwdata[test_mode_bit];
      if (r.test_mode) begin
        // Only output bits take the write; input bits stay read-only
        next_r.first_sh = pwdata[first_port_lsb +: port_width] & first_out_mask;
        next_r.second_sh = pwdata[second_port_lsb +: port_width] & second_out_mask;
        req_update = 1'b1;
      end
      if (pwdata[reload_bit]) begin
        req_refresh = 1'b1;
      end
    end
    if (wr_acc && hit_ad) begin
      next_r.bus_addr = pwdata[6:0];
      req_refresh = 1'b1;
    end
    if (wr_acc && hit_mk) begin
      next_r.mask = pwdata[0];
    end
    // Expander output source: shadow in test mode, core otherwise
    src_first = next_r.test_mode ? next_r.first_sh : core_first_out;
    src_second = next_r.test_mode ? next_r.second_sh : core_second_out;
    next_r.out_first = src_first & first_out_mask;
    next_r.out_second = src_second & second_out_mask;
    // Requests made while busy are queued once so none is lost
    if (req_refresh || req_update) begin
      next_r.pending = 1'b1;
      next_r.refresh = r.refresh | req_refresh;
      if (r.state == st_idle && !r.pending) begin
        next_r.refresh = req_refresh;
      end
    end
    unique case (r.state)
      st_idle: begin
        if (r.pending) begin
          next_r.start = 1'b1;
          next_r.state = st_busy;
          next_r.pending = req_refresh || req_update;
          if (!(req_refresh || req_update)) begin
            next_r.refresh = r.refresh;
          end
        end
      end
      st_busy: begin
        if (xfer_done) begin
          set_done = 1'b1;
          next_r.state = st_idle;
        end
      end
    endcase
    // Write one clears done, a simultaneous completion wins
    if (wr_acc && ((hit_if && pwdata[done_bit]) || (hit_st && pwdata[0]))) begin
      next_r.done = 1'b0;
    end
    if (set_done) begin
      next_r.done = 1'b1;
    end
    next_r.irq = next_r.done && next_r.mask;
  end

  // Single register stage for all state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.state <= st_idle;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.rdata;
  assign pready = r.ready;
  assign pslverr = r.slverr;
  assign expander_first_out = r.out_first;
  assign expander_second_out = r.out_second;
  assign xfer_start = r.start;
  assign xfer_refresh = r.refresh;
  assign irq = r.irq;

  // Register map at a glance: 0x0B8 holds shadows, reload, test mode and done;
  // 0x0C0 shows done as an interrupt status bit; 0x0C4 is its mask; 0x0C8 holds
  // the expander bus address, whose write also refreshes the expander.
  // Any other offset answers with an error and has no effect.
  // The checks below watch registered outputs, so an expectation launched by a
  // bus access looks one edge back with $past.

  // Named steps shared by the bus and transaction checks
  sequence s_bus_answer;
    pready ##1 !pready;
  endsequence
  sequence s_xfer_issue;
    xfer_start ##1 !xfer_start;
  endsequence

  // Done follows a completion seen while busy
  chk_done_on_complete: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == st_busy && xfer_done) |=> r.done)
    else $error("done not set");

  // Test mode drives the written shadow to the expander, both ports
  chk_test_drive: assert property (@(posedge pclk) disable iff (!presetn)
    r.test_mode |-> expander_first_out == (r.first_sh & first_out_mask))
    else $error("test mode output wrong");
  chk_test_second: assert property (@(posedge pclk) disable iff (!presetn)
    r.test_mode |-> expander_second_out == (r.second_sh & second_out_mask))
    else $error("test mode second output wrong");

  // Outside test mode the core is followed one edge later; the first edge
  // after reset is skipped since the output register has not loaded yet
  chk_core_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (!r.test_mode && $past(presetn))
      |-> expander_first_out == ($past(core_first_out) & first_out_mask))
    else $error("core not followed");
  chk_core_second: assert property (@(posedge pclk) disable iff (!presetn)
    (!r.test_mode && $past(presetn))
      |-> expander_second_out == ($past(core_second_out) & second_out_mask))
    else $error("core not followed on second port");

  // Reload and reserved bits never read back as one
  chk_reload_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> !prdata[reload_bit])
    else $error("reload read nonzero");
  chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> prdata[23:16] == 8'h00)
    else $error("reserved nonzero");
  chk_reserved_high: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && $past(hit_if)) |-> prdata[30:26] == 5'h00)
    else $error("upper reserved nonzero");

  // Shadow writes: dropped without test mode, taken output bits only with it
  chk_write_dropped: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_if && !r.test_mode) |=> $stable(r.first_sh) && $stable(r.second_sh))
    else $error("shadow written outside test mode");
  chk_shadow_take: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_if && r.test_mode) |=> r.first_sh == (8'($past(pwdata)) & first_out_mask))
    else $error("shadow write not taken");

  // A reload from idle starts a full refresh two edges after it is taken
  chk_reload_start: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_if && pwdata[reload_bit] && r.state == st_idle && !r.pending)
      |-> ##2 (xfer_start && xfer_refresh))
    else $error("reload did not start");

  // Writing the bus address also runs a refresh
  chk_addr_refresh: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_ad && r.state == st_idle && !r.pending)
      |-> ##2 (xfer_start && xfer_refresh))
    else $error("address write did not start");

  // Only one transaction at a time on the expander link
  chk_busy_single: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == st_busy) |=> !xfer_start)
    else $error("start while busy");

  // Every issued transaction is a one-cycle pulse
  chk_xfer_issue: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == st_idle && r.pending) |=> s_xfer_issue)
    else $error("transaction pulse wrong");

  // Input bits never hold written data, in the shadow or at the expander
  chk_input_ro: assert property (@(posedge pclk) disable iff (!presetn)
    ((r.first_sh & ~first_out_mask) == 8'h00) && ((r.second_sh & ~second_out_mask) == 8'h00))
    else $error("input bit written");
  chk_out_inputs: assert property (@(posedge pclk) disable iff (!presetn)
    ((expander_first_out & ~first_out_mask) == 8'h00)
      && ((expander_second_out & ~second_out_mask) == 8'h00))
    else $error("input bit driven");

  // A test-mode shadow write from idle starts an output update
  chk_update_start: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_if && r.test_mode && !pwdata[reload_bit] && r.state == st_idle
      && !r.pending) |-> ##2 (xfer_start && !xfer_refresh))
    else $error("update not started");

  // Read view merges driven outputs with sampled inputs
  chk_read_first: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && hit_if)
      |=> prdata[7:0] == merge($past(r.out_first), $past(expander_first_in), first_out_mask))
    else $error("first port read view wrong");
  chk_read_second: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && hit_if)
      |=> prdata[15:8] == merge($past(r.out_second), $past(expander_second_in), second_out_mask))
    else $error("second port read view wrong");

  // Status view of done and its write-one clear
  chk_status_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && hit_st) |=> prdata[0] == $past(r.done))
    else $error("status read wrong");
  chk_done_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_st && pwdata[0] && !(r.state == st_busy && xfer_done)) |=> !r.done)
    else $error("done not cleared");

  // Every bus access is answered by a single ready pulse
  chk_bus_answer: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> s_bus_answer)
    else $error("bus answer wrong");

  // Unmapped offsets answer with an error
  chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready && !(hit_if || hit_st || hit_mk || hit_ad)) |=> pslverr)
    else $error("unmapped access without error");

  // Interrupt level tracks unmasked done
  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> irq == (r.done && r.mask))
    else $error("interrupt level wrong");
endmodule

// *** verification/expander_model.sv ***
// Behavioural SMBus I/O expander answering the block's transaction requests
`timescale 1ns/10ps
module expander_model #(
  parameter int delay = 6  // Cycles from start to done
) (
  input wire logic pclk,  // Core clock
  input wire logic presetn,  // Asynchronous reset, active low
  input wire logic xfer_start,  // Transaction request pulse
  input wire logic xfer_refresh,  // Full refresh when high
  input wire logic [7:0] out_first,  // Outputs offered, first port
  input wire logic [7:0] out_second,  // Outputs offered, second port
  input wire logic [7:0] pin_first,  // Pin levels at the expander, first port
  input wire logic [7:0] pin_second,  // Pin levels at the expander, second port
  output logic xfer_done,  // One-cycle completion pulse
  output logic [7:0] in_first,  // Inputs last read, first port
  output logic [7:0] in_second,  // Inputs last read, second port
  output logic [7:0] seen_first,  // Outputs last written, first port
  output logic [7:0] seen_second  // Outputs last written, second port
);
  logic [7:0] cnt;
  logic refresh;
  // Inputs only change at a refresh, so reads show the last sampled pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      refresh <= 1'b0;
      xfer_done <= 1'b0;
      in_first <= 8'h00;
      in_second <= 8'h00;
      seen_first <= 8'h00;
      seen_second <= 8'h00;
    end else begin
      xfer_done <= 1'b0;
      if (xfer_start) begin
        cnt <= 8'(delay);
        refresh <= xfer_refresh;
      end else if (cnt == 8'h01) begin
        cnt <= 8'h00;
        xfer_done <= 1'b1;
        seen_first <= out_first;
        seen_second <= out_second;
        if (refresh) begin
          in_first <= pin_first;
          in_second <= pin_second;
        end
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

// *** verification/hotplug_expander_regs_test.sv ***
// Self-checking bench for the hot-plug expander register bank
`timescale 1ns/10ps
`define check(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin errors++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module hotplug_expander_regs_test;
  import hotplug_expander_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, xfer_start, xfer_refresh;
  logic xfer_done, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] core_first, core_second, out_first, out_second, in_first, in_second;
  logic [7:0] pin_first, pin_second, seen_first, seen_second;
  int errors, n_tests;
  hotplug_expander_regs i_hotplug_expander_regs (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_first_out(core_first),
    .core_second_out(core_second), .expander_first_out(out_first),
    .expander_second_out(out_second), .xfer_start(xfer_start), .xfer_refresh(xfer_refresh),
    .xfer_done(xfer_done), .expander_first_in(in_first), .expander_second_in(in_second),
    .irq(irq));
  expander_model i_expander_model (.pclk(pclk), .presetn(presetn), .xfer_start(xfer_start),
    .xfer_refresh(xfer_refresh), .out_first(out_first), .out_second(out_second),
    .pin_first(pin_first), .pin_second(pin_second), .xfer_done(xfer_done),
    .in_first(in_first), .in_second(in_second), .seen_first(seen_first),
    .seen_second(seen_second));
  // One APB transfer; an idle edge after it keeps drivers from double assignment
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Poll the interface register until the done flag shows, bounded
  task automatic wait_done();
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[done_bit] !== 1'b1 && n < 40) begin
      apb(1'b0, interface_offset, 32'h0);
      n++;
    end
    if (rd[done_bit] !== 1'b1) errors++;
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Watchdog, far beyond the roughly 120 cycles the sequence needs
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    print_verdict();
  end
  // Output bits 3:0 by default mask; bits 7:4 are expander inputs
  initial begin
    errors = 0;
    n_tests = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    core_first = 8'hA5;
    core_second = 8'h3C;
    pin_first = 8'h90;
    pin_second = 8'h60;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, interface_offset, 32'h0);
    `check("reset view", 32'h00000C05, rd)
    apb(1'b1, interface_offset, 32'h01000000);
    wait_done();
    `check("refresh view", 32'h80006C95, rd)
    `check("irq masked", 1'b0, irq)
    apb(1'b1, interface_offset, 32'hBCFFFFFF);
    apb(1'b0, interface_offset, 32'h0);
    `check("ignored write", 32'h00006C95, rd)
    apb(1'b1, interface_offset, 32'h02000000);
    repeat (20) @(posedge pclk);
    apb(1'b1, interface_offset, 32'h82000000);
    apb(1'b1, interface_offset, 32'h02000A0B);
    wait_done();
    `check("test view", 32'h82006A9B, rd)
    `check("first out", 8'h0B, out_first)
    `check("second out", 8'h0A, out_second)
    `check("sent first", 8'h0B, seen_first)
    apb(1'b1, irq_mask_offset, 32'h1);
    `check("irq raised", 1'b1, irq)
    apb(1'b1, irq_status_offset, 32'h1);
    apb(1'b0, interface_offset, 32'h0);
    `check("done cleared", 1'b0, rd[done_bit])
    `check("irq cleared", 1'b0, irq)
    apb(1'b1, bus_address_offset, 32'h20);
    wait_done();
    `check("addr done", 1'b1, irq)
    apb(1'b0, 12'h0FC, 32'h0);
    `check("unmapped err", 1'b1, err)
    `check("unmapped data", 32'h0, rd)
    apb(1'b1, interface_offset, 32'h80000000);
    repeat (3) @(posedge pclk);
    `check("core first", 8'h05, out_first)
    `check("core second", 8'h0C, out_second)
    print_verdict();
  end
endmodule
